// *** logic/four_channel_pwm_unit.sv ***
// Four-channel 10-bit PWM unit with its register port
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "pwm_cfg.svh"
module four_channel_pwm_unit (
	input  wire logic       SYS_CLK,
	input  wire logic       RESETN,
	input  wire logic [7:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic [7:0]      RDATA,
	input  wire logic       TIMER0_OVERFLOW,
	input  wire logic       TIMER0_INPUT_PIN,
	input  wire logic       GLOBAL_IRQ_ENABLE,
	output logic [3:0]      PORT4_PWM_OUT,
	output logic            PORT4_PWM_OE,
	output logic [3:0]      PORT2_PWM_OUT,
	output logic            PORT2_PWM_OE,
	output logic            PULSE_IRQ_REQ,
	output logic [7:0]      PULSE_IRQ_VECTOR
);
	import pwm_pkg::*;

	pwm_state_t s_r;
	pwm_state_t s_nxt;
	logic       tick;
	logic       overflow;
	logic [2:0] hi_slot;
	logic [2:0] lo_slot;
	logic [3:0] level;

	// Slot is {hit, channel}; used by both write and read decode
	function automatic logic [2:0] high_slot(input logic [7:0] a);
		case (a)
			`PWM_ADDR_D0H: high_slot = 3'h4;
			`PWM_ADDR_D1H: high_slot = 3'h5;
			`PWM_ADDR_D2H: high_slot = 3'h6;
			`PWM_ADDR_D3H: high_slot = 3'h7;
			default:       high_slot = 3'h0;
		endcase
	endfunction : high_slot

	function automatic logic [2:0] low_slot(input logic [7:0] a);
		case (a)
			`PWM_ADDR_D0L: low_slot = 3'h4;
			`PWM_ADDR_D1L: low_slot = 3'h5;
			`PWM_ADDR_D2L: low_slot = 3'h6;
			`PWM_ADDR_D3L: low_slot = 3'h7;
			default:       low_slot = 3'h0;
		endcase
	endfunction : low_slot

	pwm_clock_select u_clock_select (
		.clk        (SYS_CLK),
		.rst_n      (RESETN),
		.sel        (s_r.clk_src),
		.timer0_ovf (TIMER0_OVERFLOW),
		.timer0_pin (TIMER0_INPUT_PIN),
		.tick       (tick)
	);

	// One comparator per channel against the shared count
	for (genvar g = 0; g < 4; g++) begin : gen_chan
		assign level[g] = (s_r.chan_en[g] && (s_r.duty[g] != 10'h000) &&
			(s_r.cnt < s_r.duty[g])) ? ~s_r.pol[g]
			: s_r.pol[g];
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.rdata = 8'h00;
		overflow = 1'b0;
		hi_slot = high_slot(ADDR);
		lo_slot = low_slot(ADDR);

		// Register writes
		if (WR) begin
			if (hi_slot[2]) begin
				s_nxt.pol[hi_slot[1:0]] =
					WDATA[`PWM_HIGH_POL_BIT];
				s_nxt.duty[hi_slot[1:0]][9:8] =
					WDATA[1:0];
			end
			if (lo_slot[2]) begin
				s_nxt.duty[lo_slot[1:0]][7:0] =
					WDATA;
			end
			if (ADDR == `PWM_ADDR_PIN_SEL) begin
				s_nxt.port_sel =
					WDATA[`PWM_PIN_SEL_BIT];
			end
			if (ADDR == `PWM_ADDR_CTRL) begin
				s_nxt.clk_src = clk_src_t'(
					WDATA[`PWM_CTRL_CS_HI:`PWM_CTRL_CS_LO]);
				s_nxt.chan_en =
					WDATA[`PWM_CTRL_EN_HI:0];
			end
			if (ADDR == `PWM_ADDR_MAXH) begin
				s_nxt.max[9:8] = WDATA[1:0];
			end
			if (ADDR == `PWM_ADDR_MAXL) begin
				s_nxt.max[7:0] = WDATA;
			end
			if (ADDR == `PWM_ADDR_IRQ_EN) begin
				s_nxt.ien = WDATA[`PWM_IEN_BIT];
			end
			if (ADDR == `PWM_ADDR_IRQ_REQ) begin
				// Flag stays until software writes it low
				s_nxt.flag = WDATA[`PWM_FLAG_BIT];
			end
		end

		// Register reads, answered in the following cycle
		if (RD) begin
			if (hi_slot[2]) begin
				s_nxt.rdata[`PWM_HIGH_POL_BIT] = s_r.pol[hi_slot[1:0]];
				s_nxt.rdata[1:0] = s_r.duty[hi_slot[1:0]][9:8];
			end
			if (lo_slot[2]) begin
				s_nxt.rdata = s_r.duty[lo_slot[1:0]][7:0];
			end
			if (ADDR == `PWM_ADDR_PIN_SEL) begin
				s_nxt.rdata[`PWM_PIN_SEL_BIT] = s_r.port_sel;
			end
			if (ADDR == `PWM_ADDR_CTRL) begin
				s_nxt.rdata[`PWM_CTRL_CS_HI:`PWM_CTRL_CS_LO] =
					s_r.clk_src;
				s_nxt.rdata[`PWM_CTRL_EN_HI:0] = s_r.chan_en;
			end
			if (ADDR == `PWM_ADDR_MAXH) begin
				s_nxt.rdata[1:0] = s_r.max[9:8];
			end
			if (ADDR == `PWM_ADDR_MAXL) begin
				s_nxt.rdata = s_r.max[7:0];
			end
			if (ADDR == `PWM_ADDR_IRQ_EN) begin
				s_nxt.rdata[`PWM_IEN_BIT] = s_r.ien;
			end
			if (ADDR == `PWM_ADDR_IRQ_REQ) begin
				s_nxt.rdata[`PWM_FLAG_BIT] = s_r.flag;
			end
		end

		// Shared counter, one step per counter clock enable
		if (tick) begin
			// A maximum lowered below the count wraps at once
			// instead of running the counter out to 1023
			if (s_r.cnt >= s_r.max) begin
				s_nxt.cnt = 10'h000;
				overflow = 1'b1;
			end else begin
				s_nxt.cnt = s_r.cnt + 10'h001;
			end
		end

		// Hardware set beats a same-cycle software clear
		if (overflow) begin
			s_nxt.flag = 1'b1;
		end

		// Pins not selected are released to their port
		if (s_r.port_sel) begin
			s_nxt.p2 = level;
			s_nxt.p2_oe = 1'b1;
			s_nxt.p4 = 4'h0;
			s_nxt.p4_oe = 1'b0;
		end else begin
			s_nxt.p4 = level;
			s_nxt.p4_oe = 1'b1;
			s_nxt.p2 = 4'h0;
			s_nxt.p2_oe = 1'b0;
		end

		s_nxt.irq = s_r.flag & s_r.ien &
			GLOBAL_IRQ_ENABLE;
		s_nxt.vector = `PWM_IRQ_VECTOR;
	end

	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			s_r <= '0;
			s_r.max <= `PWM_MAX_RESET;
			s_r.vector <= `PWM_IRQ_VECTOR;
			s_r.p4_oe <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign RDATA = s_r.rdata;
	assign PORT4_PWM_OUT = s_r.p4;
	assign PORT4_PWM_OE = s_r.p4_oe;
	assign PORT2_PWM_OUT = s_r.p2;
	assign PORT2_PWM_OE = s_r.p2_oe;
	assign PULSE_IRQ_REQ = s_r.irq;
	assign PULSE_IRQ_VECTOR = s_r.vector;

endmodule : four_channel_pwm_unit

// *** logic/pwm_cfg.svh ***
// Offsets, field positions, reset values and divider counts of the PWM unit
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH
`define PWM_ADDR_PIN_SEL    8'h91
`define PWM_ADDR_D2H        8'hb1
`define PWM_ADDR_D2L        8'hb2
`define PWM_ADDR_D3H        8'hb3
`define PWM_ADDR_D3L        8'hb4
`define PWM_ADDR_CTRL       8'hb5
`define PWM_ADDR_IRQ_EN     8'hb8
`define PWM_ADDR_D0H        8'hbc
`define PWM_ADDR_D0L        8'hbd
`define PWM_ADDR_D1H        8'hbe
`define PWM_ADDR_D1L        8'hbf
`define PWM_ADDR_IRQ_REQ    8'hc0
`define PWM_ADDR_MAXH       8'hce
`define PWM_ADDR_MAXL       8'hcf
`define PWM_PIN_SEL_BIT     1
`define PWM_CTRL_CS_HI      7
`define PWM_CTRL_CS_LO      5
`define PWM_CTRL_EN_HI      3
`define PWM_HIGH_POL_BIT    7
`define PWM_IEN_BIT         0
`define PWM_FLAG_BIT        0
`define PWM_MAX_RESET       10'h0ff
`define PWM_IRQ_VECTOR      8'h43
`define PWM_DIV_LAST_FOSC   4'h0
`define PWM_DIV_LAST_2      4'h1
`define PWM_DIV_LAST_4      4'h3
`define PWM_DIV_LAST_6      4'h5
`define PWM_DIV_LAST_8      4'h7
`define PWM_DIV_LAST_12     4'hb
`endif

// *** logic/pwm_clock_select.sv ***
// Counter clock enable: oscillator divider or timer 0 sources
`timescale 1ns/1ps
`include "pwm_cfg.svh"
module pwm_clock_select (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire pwm_pkg::clk_src_t sel,
	input  wire logic              timer0_ovf,
	input  wire logic              timer0_pin,
	output logic                   tick
);
	import pwm_pkg::*;

	div_state_t s_r;
	div_state_t s_nxt;
	logic [3:0] last;
	logic       div_tick;

	function automatic logic [3:0] last_count(input clk_src_t src);
		case (src)
			SRC_DIV2:  last_count = `PWM_DIV_LAST_2;
			SRC_DIV4:  last_count = `PWM_DIV_LAST_4;
			SRC_DIV6:  last_count = `PWM_DIV_LAST_6;
			SRC_DIV8:  last_count = `PWM_DIV_LAST_8;
			SRC_DIV12: last_count = `PWM_DIV_LAST_12;
			default:   last_count = `PWM_DIV_LAST_FOSC;
		endcase
	endfunction : last_count

	always_comb begin
		s_nxt = s_r;
		last = last_count(sel);
		div_tick = 1'b0;
		// Compare with >= so a switch to a faster ratio never overruns
		if (s_r.div_cnt >= last) begin
			s_nxt.div_cnt = 4'h0;
			div_tick = 1'b1;
		end else begin
			s_nxt.div_cnt = s_r.div_cnt + 4'h1;
		end
		s_nxt.pin_prev = timer0_pin;
		if (sel == SRC_TMR_OVF) begin
			tick = timer0_ovf;
		end else if (sel == SRC_TMR_PIN) begin
			tick = timer0_pin & ~s_r.pin_prev;
		end else begin
			tick = div_tick;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

endmodule : pwm_clock_select

// *** logic/pwm_pkg.sv ***
// Types shared by the PWM unit and its clock selector
package pwm_pkg;

	typedef enum logic [2:0] {
		SRC_FOSC    = 3'b000,
		SRC_DIV2    = 3'b001,
		SRC_DIV4    = 3'b010,
		SRC_DIV6    = 3'b011,
		SRC_DIV8    = 3'b100,
		SRC_DIV12   = 3'b101,
		SRC_TMR_OVF = 3'b110,
		SRC_TMR_PIN = 3'b111
	} clk_src_t;

	typedef struct packed {
		logic [3:0] div_cnt;
		logic       pin_prev;
	} div_state_t;

	typedef struct packed {
		logic            port_sel;
		clk_src_t        clk_src;
		logic [3:0]      chan_en;
		logic [3:0]      pol;
		logic [3:0][9:0] duty;
		logic [9:0]      max;
		logic            ien;
		logic            flag;
		logic [9:0]      cnt;
		logic [7:0]      rdata;
		logic [3:0]      p4;
		logic            p4_oe;
		logic [3:0]      p2;
		logic            p2_oe;
		logic            irq;
		logic [7:0]      vector;
	} pwm_state_t;

endpackage : pwm_pkg

// *** test/four_channel_pwm_unit_tb_top.sv ***
// Self-checking bench for the four-channel PWM unit
`timescale 1ns/1ps
module four_channel_pwm_unit_tb_top;
	logic            SYS_CLK = 1'b0, RESETN = 1'b0, WR = 1'b0, RD = 1'b0;
	logic            GLOBAL_IRQ_ENABLE = 1'b0, clr = 1'b0, win = 1'b0;
	logic            TIMER0_OVERFLOW = 1'b0, TIMER0_INPUT_PIN = 1'b0;
	logic            tmr_on = 1'b1, PORT4_PWM_OE, PORT2_PWM_OE, PULSE_IRQ_REQ;
	logic [7:0]      ADDR = 8'h00, WDATA = 8'h00, RDATA, PULSE_IRQ_VECTOR, d;
	logic [3:0]      PORT4_PWM_OUT, PORT2_PWM_OUT;
	logic [1:0]      tc = 2'h0;
	logic [3:0][9:0] hc;
	int              fails = 0, checks = 0, cyc = 0;
	four_channel_pwm_unit dut (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
		.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.TIMER0_OVERFLOW(TIMER0_OVERFLOW),
		.TIMER0_INPUT_PIN(TIMER0_INPUT_PIN),
		.GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .PORT4_PWM_OUT(PORT4_PWM_OUT),
		.PORT4_PWM_OE(PORT4_PWM_OE), .PORT2_PWM_OUT(PORT2_PWM_OUT),
		.PORT2_PWM_OE(PORT2_PWM_OE), .PULSE_IRQ_REQ(PULSE_IRQ_REQ),
		.PULSE_IRQ_VECTOR(PULSE_IRQ_VECTOR));
	pwm_load_model load (.clk(SYS_CLK), .p4(PORT4_PWM_OUT),
		.p4_oe(PORT4_PWM_OE), .p2(PORT2_PWM_OUT), .p2_oe(PORT2_PWM_OE),
		.clr(clr), .win(win), .hc(hc));
	initial forever #5 SYS_CLK = ~SYS_CLK;
	// Timer 0 stand-in, gated so a test can freeze the count
	always @(posedge SYS_CLK) begin
		tc <= (tc == 2'h2) ? 2'h0 : tc + 2'h1;
		TIMER0_OVERFLOW <= tmr_on && tc == 2'h2;
		TIMER0_INPUT_PIN <= tmr_on && tc == 2'h2;
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			fails++;
			complete_run();
		end
	end
	task chk(input string n, input logic [9:0] seen, input logic [9:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge SYS_CLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= v;
		@(posedge SYS_CLK);
		WR <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge SYS_CLK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge SYS_CLK);
		RD <= 1'b0;
		#1 d = RDATA;
	endtask : rd
	// Windows span whole periods, so the phase does not matter
	task measure(input int n);
		clr <= 1'b1;
		@(posedge SYS_CLK);
		clr <= 1'b0;
		win <= 1'b1;
		repeat (n) @(posedge SYS_CLK);
		win <= 1'b0;
		#1;
	endtask : measure
	task complete_run;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	task reset_values;
		logic [7:0] a [15] = '{8'h91, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb5,
			8'hbc, 8'hbd, 8'hbe, 8'hbf, 8'hce, 8'hcf, 8'hb8, 8'hc0, 8'h00};
		foreach (a[i]) begin
			rd(a[i]);
			chk("reset", {2'h0, d}, a[i] == 8'hcf ? 10'h0ff : 10'h0);
		end
		chk("vector", {2'h0, PULSE_IRQ_VECTOR}, 10'h043);
	endtask : reset_values
	task duty_shapes;
		wr(8'hce, 8'h01);
		wr(8'hcf, 8'h03);
		wr(8'hbd, 8'h01);
		wr(8'hbe, 8'h80);
		wr(8'hbf, 8'h02);
		wr(8'hb1, 8'h01);
		wr(8'hb3, 8'h80);
		wr(8'hb4, 8'h01);
		wr(8'hb5, 8'h07);
		measure(520);
		chk("ch0", hc[0], 10'h002);
		chk("ch1", hc[1], 10'h204);
		chk("ch2", hc[2], 10'h200);
		chk("ch3", hc[3], 10'h208);
		wr(8'hbd, 8'h00);
		measure(520);
		chk("ch0 zero", hc[0], 10'h000);
	endtask : duty_shapes
	task clock_sources;
		int dv [8] = '{1, 2, 4, 6, 8, 12, 3, 3};
		wr(8'hce, 8'h00);
		wr(8'hbd, 8'h01);
		for (int s = 0; s < 8; s++) begin
			wr(8'hb5, {s[2:0], 5'h01});
			repeat (8 * dv[s]) @(posedge SYS_CLK);
			measure(8 * dv[s]);
			chk("source", hc[0], 10'(2 * dv[s]));
		end
	endtask : clock_sources
	task port_select;
		wr(8'hb5, 8'h01);
		wr(8'h91, 8'h02);
		measure(8);
		chk("p2 oe", {9'h0, PORT2_PWM_OE}, 10'h001);
		chk("p4 oe", {9'h0, PORT4_PWM_OE}, 10'h000);
		chk("p2 ch0", hc[0], 10'h002);
		wr(8'h91, 8'h00);
	endtask : port_select
	task irq_path;
		wr(8'hb5, 8'hc1);
		wr(8'hc0, 8'h00);
		wr(8'hb8, 8'h01);
		GLOBAL_IRQ_ENABLE <= 1'b1;
		repeat (20) @(posedge SYS_CLK);
		rd(8'hc0);
		chk("flag", {2'h0, d}, 10'h001);
		chk("irq", {9'h0, PULSE_IRQ_REQ}, 10'h001);
		@(posedge SYS_CLK);
		tmr_on <= 1'b0;
		wr(8'hc0, 8'h00);
		rd(8'hc0);
		chk("flag clear", {2'h0, d}, 10'h000);
		@(posedge SYS_CLK);
		tmr_on <= 1'b1;
		GLOBAL_IRQ_ENABLE <= 1'b0;
		repeat (20) @(posedge SYS_CLK);
		#1 chk("masked", {9'h0, PULSE_IRQ_REQ}, 10'h000);
		rd(8'hc0);
		chk("flag again", {2'h0, d}, 10'h001);
		@(posedge SYS_CLK);
		GLOBAL_IRQ_ENABLE <= 1'b1;
		wr(8'hb8, 8'h00);
		repeat (2) @(posedge SYS_CLK);
		#1 chk("ien off", {9'h0, PULSE_IRQ_REQ}, 10'h000);
	endtask : irq_path
	initial begin
		repeat (6) @(posedge SYS_CLK);
		RESETN <= 1'b1;
		@(posedge SYS_CLK);
		reset_values();
		duty_shapes();
		clock_sources();
		port_select();
		irq_path();
		complete_run();
	end
endmodule : four_channel_pwm_unit_tb_top

// *** test/pwm_load_model.sv ***
// Load on the PWM pins: counts high cycles per channel
`timescale 1ns/1ps
module pwm_load_model (
	input  wire logic       clk,
	input  wire logic [3:0] p4,
	input  wire logic       p4_oe,
	input  wire logic [3:0] p2,
	input  wire logic       p2_oe,
	input  wire logic       clr,
	input  wire logic       win,
	output logic [3:0][9:0] hc
);
	logic [3:0] lvl;
	// Undriven pins float to the pull-up, never the last level
	assign lvl = p4_oe ? p4 : (p2_oe ? p2 : 4'hf);
	always_ff @(posedge clk) begin
		for (int i = 0; i < 4; i++)
			hc[i] <= clr ? 10'h0 : hc[i] + {9'h0, win & lvl[i]};
	end
endmodule : pwm_load_model

// *** test/pwm_unit_assertions.sv ***
// Port-level assertions for the PWM unit
`timescale 1ns/1ps
module pwm_unit_checker (
	input wire logic       SYS_CLK,
	input wire logic       RESETN,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic       WR,
	input wire logic       RD,
	input wire logic [7:0] RDATA,
	input wire logic       GLOBAL_IRQ_ENABLE,
	input wire logic [3:0] PORT4_PWM_OUT,
	input wire logic       PORT4_PWM_OE,
	input wire logic [3:0] PORT2_PWM_OUT,
	input wire logic       PORT2_PWM_OE,
	input wire logic       PULSE_IRQ_REQ,
	input wire logic [7:0] PULSE_IRQ_VECTOR
);
	default clocking dc @(posedge SYS_CLK);
	endclocking
	default disable iff (!RESETN);
	chk_vector_fixed: assert property (
		PULSE_IRQ_VECTOR == 8'h43) else $error("bad vector");
	chk_one_port: assert property (
		PORT4_PWM_OE != PORT2_PWM_OE) else $error("port clash");
	chk_p4_quiet: assert property (
		!PORT4_PWM_OE |-> PORT4_PWM_OUT == 4'h0) else $error("p4 busy");
	chk_p2_quiet: assert property (
		!PORT2_PWM_OE |-> PORT2_PWM_OUT == 4'h0) else $error("p2 busy");
	chk_port_switch: assert property (
		WR && ADDR == 8'h91 && WDATA[1] |-> ##[1:2] PORT2_PWM_OE)
		else $error("no switch");
	chk_pinsel_reserved: assert property (
		RD && ADDR == 8'h91 |=> (RDATA & 8'hfd) == 8'h00)
		else $error("aux bits");
	chk_irq_global: assert property (
		!GLOBAL_IRQ_ENABLE |=> !PULSE_IRQ_REQ) else $error("irq unmasked");
	chk_ien_clear: assert property (
		WR && ADDR == 8'hb8 && !WDATA[0] |=> ##1 !PULSE_IRQ_REQ)
		else $error("ien ignored");
endmodule : pwm_unit_checker
bind four_channel_pwm_unit pwm_unit_checker chk (.SYS_CLK(SYS_CLK),
	.RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
	.RDATA(RDATA), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
	.PORT4_PWM_OUT(PORT4_PWM_OUT), .PORT4_PWM_OE(PORT4_PWM_OE),
	.PORT2_PWM_OUT(PORT2_PWM_OUT), .PORT2_PWM_OE(PORT2_PWM_OE),
	.PULSE_IRQ_REQ(PULSE_IRQ_REQ), .PULSE_IRQ_VECTOR(PULSE_IRQ_VECTOR));
